/* File: design/sspc_ctrl.sv */
// host controller: apb registers, serial master and pin drive for the video switch
//
// Contract
// - reset pin held high in normal operation
// - start opens, stop ends, bus released
// - seven-bit address, prefix plus select pins
// - write direction bit zero, device acknowledges
// - register pointer byte follows, acknowledged
// - one data byte stored, acknowledged
// - after write ack: stop or repeated start
// - read: pointer write, repeated start, address+1
// - master acknowledges read byte, then stop
// - channel select change followed by reset pulse
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "sspc_map.svh"
module sspc_ctrl #(
    parameter logic [3:0]  DEV_PREFIX  = `SSPC_DEV_PREFIX, // arbitrary value
    parameter logic [15:0] RST_LOW_CYC = 16'(`SSPC_RST_LOW_CYC)
) (
    input  wire logic               clock,
    input  wire logic               srst,
    input  wire logic [7:0]         paddr,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               sclIn,
    output logic                    sclOut,
    output logic                    sclOe,
    input  wire logic               sdaIn,
    output logic                    sdaOut,
    output logic                    sdaOe,
    output logic                    devResetN,
    output logic                    slaveAddrSelBit2,
    output logic                    slaveAddrSelBit1,
    output logic                    slaveAddrSelBit0,
    output sspc_pkg::sspc_par_t     parPins
);

    ////////////////////////////////////////////////////////////////////////////////////////
    // declarations

    logic [31:0]          prdata_ff;
    logic                 pready_ff;
    logic                 pslverr_ff;
    logic [2:0]           addrSel_ff;
    logic [7:0]           regAddr_ff;
    logic [7:0]           wdata_ff;
    sspc_pkg::sspc_par_t  par_ff;
    sspc_pkg::sspc_kind_t startKind_ff;
    sspc_pkg::sspc_kind_t kind_ff;
    logic                 rstReq_ff;
    logic                 rstPend_ff;
    logic [15:0]          rstCnt_ff;
    logic                 rstActive_ff;
    logic                 devResetN_ff;
    sspc_pkg::sspc_state_t state_ff;
    sspc_pkg::sspc_op_t   op_ff;
    logic [2:0]           idx_ff;
    logic [1:0]           phase_ff;
    logic [3:0]           bitCnt_ff;
    logic [7:0]           shift_ff;
    logic                 sclOe_ff;
    logic                 sdaOe_ff;
    logic                 sclOut_ff;
    logic                 sdaOut_ff;
    logic                 nack_ff;
    logic                 serialUsed_ff;
    logic [7:0]           rdData_ff;
    logic [1:0]           pinSync;
    logic                 sclSync;
    logic                 sdaSync;
    logic                 tick;
    logic                 apbWr;
    logic                 busy;
    sspc_pkg::sspc_op_t   nxtOp;

    ////////////////////////////////////////////////////////////////////////////////////////
    // step sequence of each transaction kind

    function automatic sspc_pkg::sspc_op_t stepOp(input sspc_pkg::sspc_kind_t k,
                                                  input logic [2:0] i);
        sspc_pkg::sspc_op_t o;
        o = sspc_pkg::OP_STOP;
        case (k)
            sspc_pkg::K_WRITE: begin
                case (i)
                    3'h0:    o = sspc_pkg::OP_START;
                    3'h1:    o = sspc_pkg::OP_TXAW;
                    3'h2:    o = sspc_pkg::OP_TXREG;
                    3'h3:    o = sspc_pkg::OP_TXDATA;
                    default: o = sspc_pkg::OP_STOP;
                endcase
            end
            sspc_pkg::K_READ: begin
                case (i)
                    3'h0:    o = sspc_pkg::OP_START;
                    3'h1:    o = sspc_pkg::OP_TXAW;
                    3'h2:    o = sspc_pkg::OP_TXREG;
                    3'h3:    o = sspc_pkg::OP_START;
                    3'h4:    o = sspc_pkg::OP_TXAR;
                    3'h5:    o = sspc_pkg::OP_RX;
                    default: o = sspc_pkg::OP_STOP;
                endcase
            end
            sspc_pkg::K_CUR: begin
                case (i)
                    3'h0:    o = sspc_pkg::OP_START;
                    3'h1:    o = sspc_pkg::OP_TXAR;
                    3'h2:    o = sspc_pkg::OP_RX;
                    default: o = sspc_pkg::OP_STOP;
                endcase
            end
            default: o = sspc_pkg::OP_STOP;
        endcase
        return o;
    endfunction : stepOp

    // byte shifted for a step; all ones releases sda while receiving
    function automatic logic [7:0] stepByte(input sspc_pkg::sspc_op_t o, input logic [2:0] sel,
                                            input logic [7:0] ra, input logic [7:0] wd);
        logic [7:0] b;
        b = 8'hff;
        case (o)
            sspc_pkg::OP_TXAW:   b = {DEV_PREFIX, sel, 1'b0};
            sspc_pkg::OP_TXAR:   b = {DEV_PREFIX, sel, 1'b1};
            sspc_pkg::OP_TXREG:  b = ra;
            sspc_pkg::OP_TXDATA: b = wd;
            default:             b = 8'hff;
        endcase
        return b;
    endfunction : stepByte

    function automatic logic isCond(input sspc_pkg::sspc_op_t o);
        return (o == sspc_pkg::OP_START) || (o == sspc_pkg::OP_STOP);
    endfunction : isCond

    ////////////////////////////////////////////////////////////////////////////////////////
    // pin sampling and bit timing

    sspc_sync #(
        .W    (2)
    ) u_sync (
        .clock (clock),
        .srst  (srst),
        .din   ({sclIn, sdaIn}),
        .dout  (pinSync)
    );
    assign sclSync = pinSync[1];
    assign sdaSync = pinSync[0];

    sspc_tick u_tick (
        .clock (clock),
        .srst  (srst),
        .clr   (state_ff == sspc_pkg::ST_IDLE),
        .tick  (tick)
    );

    ////////////////////////////////////////////////////////////////////////////////////////
    // apb slave: one wait-free access phase, unmapped offsets answer pslverr

    assign apbWr = psel && penable && pwrite && pready_ff;
    assign busy  = (state_ff != sspc_pkg::ST_IDLE) || (startKind_ff != sspc_pkg::K_NONE)
                   || rstActive_ff || rstPend_ff;

    always_ff @(posedge clock) begin
        if (srst) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= psel && !penable;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
            if (psel && !penable) begin
                case (paddr)
                    `SSPC_OFF_CMD:   prdata_ff <= {30'h0, kind_ff};
                    `SSPC_OFF_ADDR:  prdata_ff <= {16'h0, regAddr_ff, 5'h0, addrSel_ff};
                    `SSPC_OFF_WDATA: prdata_ff <= {24'h0, wdata_ff};
                    `SSPC_OFF_RDATA: prdata_ff <= {24'h0, rdData_ff};
                    `SSPC_OFF_STAT:  prdata_ff <= {28'h0, rstActive_ff, serialUsed_ff,
                                                   nack_ff, busy};
                    `SSPC_OFF_PAR:   prdata_ff <= {24'h0, par_ff};
                    `SSPC_OFF_RST:   prdata_ff <= {31'h0, rstActive_ff};
                    default:         pslverr_ff <= 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            addrSel_ff   <= `SSPC_ADDR_RST;
            regAddr_ff   <= 8'h00;
            wdata_ff     <= 8'h00;
            par_ff       <= `SSPC_PAR_RST;
            startKind_ff <= sspc_pkg::K_NONE;
            rstReq_ff    <= 1'b0;
        end else begin
            rstReq_ff <= 1'b0;
            if (startKind_ff != sspc_pkg::K_NONE && state_ff == sspc_pkg::ST_IDLE
                && !rstActive_ff && !rstPend_ff) begin
                startKind_ff <= sspc_pkg::K_NONE;
            end
            if (apbWr) begin
                case (paddr)
                    `SSPC_OFF_CMD: begin
                        if (!busy) begin
                            startKind_ff <= sspc_pkg::sspc_kind_t'(pwdata[1:0]);
                        end
                    end
                    `SSPC_OFF_ADDR: begin
                        addrSel_ff <= pwdata[`SSPC_ADDR_SEL_LSB +: 3];
                        regAddr_ff <= pwdata[`SSPC_ADDR_REG_LSB +: 8];
                    end
                    `SSPC_OFF_WDATA: wdata_ff <= pwdata[7:0];
                    `SSPC_OFF_PAR: begin
                        par_ff <= sspc_pkg::sspc_par_t'(pwdata[7:0]);
                        if (pwdata[2:1] != par_ff.parSourceSelectPins) begin
                            rstReq_ff <= 1'b1;
                        end
                    end
                    `SSPC_OFF_RST: rstReq_ff <= pwdata[0];
                    default: rstReq_ff <= 1'b0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // device reset pulse, launched only while the serial bus is idle

    always_ff @(posedge clock) begin
        if (srst) begin
            rstPend_ff   <= 1'b0;
            rstActive_ff <= 1'b0;
            rstCnt_ff    <= 16'h0000;
            devResetN_ff <= 1'b1;
        end else begin
            if (rstReq_ff) begin
                rstPend_ff <= 1'b1;
            end
            if (rstPend_ff && !rstActive_ff && state_ff == sspc_pkg::ST_IDLE) begin
                rstPend_ff   <= rstReq_ff;
                rstActive_ff <= 1'b1;
                rstCnt_ff    <= RST_LOW_CYC;
                devResetN_ff <= 1'b0;
            end else if (rstActive_ff) begin
                if (rstCnt_ff == 16'h0001) begin
                    rstActive_ff <= 1'b0;
                    devResetN_ff <= 1'b1;
                end
                rstCnt_ff <= rstCnt_ff - 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // serial master: four ticks per bit or condition

    assign nxtOp = stepOp(kind_ff, idx_ff + 3'h1);

    always_ff @(posedge clock) begin
        if (srst) begin
            state_ff      <= sspc_pkg::ST_IDLE;
            op_ff         <= sspc_pkg::OP_STOP;
            kind_ff       <= sspc_pkg::K_NONE;
            idx_ff        <= 3'h0;
            phase_ff      <= 2'h0;
            bitCnt_ff     <= 4'h0;
            shift_ff      <= 8'hff;
            sclOe_ff      <= 1'b0;
            sdaOe_ff      <= 1'b0;
            nack_ff       <= 1'b0;
            serialUsed_ff <= 1'b0;
            rdData_ff     <= 8'h00;
        end else begin
            if (rstActive_ff) begin
                serialUsed_ff <= 1'b0;
            end
            case (state_ff)
                sspc_pkg::ST_IDLE: begin
                    sclOe_ff <= 1'b0;
                    sdaOe_ff <= 1'b0;
                    if (startKind_ff != sspc_pkg::K_NONE && !rstActive_ff && !rstPend_ff) begin
                        kind_ff  <= startKind_ff;
                        idx_ff   <= 3'h0;
                        op_ff    <= sspc_pkg::OP_START;
                        phase_ff <= 2'h0;
                        nack_ff  <= 1'b0;
                        state_ff <= sspc_pkg::ST_COND;
                    end
                end
                sspc_pkg::ST_COND: begin
                    if (tick) begin
                        case (phase_ff)
                            2'h0: begin
                                sclOe_ff <= 1'b1;
                                sdaOe_ff <= (op_ff == sspc_pkg::OP_STOP);
                                phase_ff <= 2'h1;
                            end
                            2'h1: begin
                                sclOe_ff <= 1'b0;
                                phase_ff <= 2'h2;
                            end
                            2'h2: begin
                                if (sclSync) begin
                                    sdaOe_ff <= (op_ff != sspc_pkg::OP_STOP);
                                    phase_ff <= 2'h3;
                                    if (op_ff == sspc_pkg::OP_START) begin
                                        serialUsed_ff <= 1'b1;
                                    end
                                end
                            end
                            default: begin
                                phase_ff <= 2'h0;
                                if (op_ff == sspc_pkg::OP_STOP) begin
                                    state_ff <= sspc_pkg::ST_IDLE;
                                end else begin
                                    sclOe_ff  <= 1'b1;
                                    idx_ff    <= idx_ff + 3'h1;
                                    op_ff     <= nxtOp;
                                    bitCnt_ff <= 4'h0;
                                    shift_ff  <= stepByte(nxtOp, addrSel_ff, regAddr_ff,
                                                          wdata_ff);
                                    state_ff  <= isCond(nxtOp) ? sspc_pkg::ST_COND
                                                               : sspc_pkg::ST_BYTE;
                                end
                            end
                        endcase
                    end
                end
                sspc_pkg::ST_BYTE: begin
                    if (tick) begin
                        case (phase_ff)
                            2'h0: begin
                                if (bitCnt_ff == 4'h8) begin
                                    sdaOe_ff <= (op_ff == sspc_pkg::OP_RX);
                                end else begin
                                    sdaOe_ff <= !shift_ff[7];
                                end
                                phase_ff <= 2'h1;
                            end
                            2'h1: begin
                                sclOe_ff <= 1'b0;
                                phase_ff <= 2'h2;
                            end
                            2'h2: begin
                                if (sclSync) begin
                                    if (bitCnt_ff == 4'h8) begin
                                        if (op_ff != sspc_pkg::OP_RX) begin
                                            nack_ff <= sdaSync;
                                        end
                                    end else begin
                                        shift_ff <= {shift_ff[6:0], sdaSync};
                                    end
                                    phase_ff <= 2'h3;
                                end
                            end
                            default: begin
                                sclOe_ff <= 1'b1;
                                phase_ff <= 2'h0;
                                if (bitCnt_ff != 4'h8) begin
                                    bitCnt_ff <= bitCnt_ff + 4'h1;
                                end else if (nack_ff) begin
                                    op_ff    <= sspc_pkg::OP_STOP;
                                    state_ff <= sspc_pkg::ST_COND;
                                end else begin
                                    if (op_ff == sspc_pkg::OP_RX) begin
                                        rdData_ff <= shift_ff;
                                    end
                                    idx_ff    <= idx_ff + 3'h1;
                                    op_ff     <= nxtOp;
                                    bitCnt_ff <= 4'h0;
                                    shift_ff  <= stepByte(nxtOp, addrSel_ff, regAddr_ff,
                                                          wdata_ff);
                                    state_ff  <= isCond(nxtOp) ? sspc_pkg::ST_COND
                                                               : sspc_pkg::ST_BYTE;
                                end
                            end
                        endcase
                    end
                end
                default: state_ff <= sspc_pkg::ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // open-drain levels stay low; only the enables move

    always_ff @(posedge clock) begin
        if (srst) begin
            sclOut_ff <= 1'b0;
            sdaOut_ff <= 1'b0;
        end else begin
            sclOut_ff <= 1'b0;
            sdaOut_ff <= 1'b0;
        end
    end

    assign prdata           = prdata_ff;
    assign pready           = pready_ff;
    assign pslverr          = pslverr_ff;
    assign sclOut           = sclOut_ff;
    assign sclOe            = sclOe_ff;
    assign sdaOut           = sdaOut_ff;
    assign sdaOe            = sdaOe_ff;
    assign devResetN        = devResetN_ff;
    assign slaveAddrSelBit2 = addrSel_ff[2];
    assign slaveAddrSelBit1 = addrSel_ff[1];
    assign slaveAddrSelBit0 = addrSel_ff[0];
    assign parPins          = par_ff;

endmodule : sspc_ctrl

/* File: design/sspc_map.svh */
// register offsets, field positions, reset values and timing counts of the switch controller
`ifndef SSPC_MAP_SVH
`define SSPC_MAP_SVH

`define SSPC_OFF_CMD       8'h00
`define SSPC_OFF_ADDR      8'h04
`define SSPC_OFF_WDATA     8'h08
`define SSPC_OFF_RDATA     8'h0c
`define SSPC_OFF_STAT      8'h10
`define SSPC_OFF_PAR       8'h14
`define SSPC_OFF_RST       8'h18

`define SSPC_CMD_KIND_LSB  0
`define SSPC_ADDR_SEL_LSB  0
`define SSPC_ADDR_REG_LSB  8
`define SSPC_STAT_BUSY     0
`define SSPC_STAT_NACK     1
`define SSPC_STAT_SERIAL   2
`define SSPC_STAT_RSTACT   3

`define SSPC_PAR_RST       8'h01
`define SSPC_ADDR_RST      3'h0
`define SSPC_DEV_PREFIX    4'h5

`define SSPC_CLK_NS        25
`define SSPC_SCL_QTR_NS    2500
`define SSPC_SCL_QTR_CYC   ((`SSPC_SCL_QTR_NS + `SSPC_CLK_NS - 1) / `SSPC_CLK_NS)
`define SSPC_RST_LOW_NS    10000
`define SSPC_RST_LOW_CYC   ((`SSPC_RST_LOW_NS + `SSPC_CLK_NS - 1) / `SSPC_CLK_NS)

`endif

/* File: design/sspc_pkg.sv */
// types shared by the switch controller modules
package sspc_pkg;

    typedef enum logic [1:0] {
        K_NONE  = 2'b00,
        K_WRITE = 2'b01,
        K_READ  = 2'b10,
        K_CUR   = 2'b11
    } sspc_kind_t;

    typedef enum logic [2:0] {
        OP_START  = 3'b000,
        OP_TXAW   = 3'b001,
        OP_TXAR   = 3'b010,
        OP_TXREG  = 3'b011,
        OP_TXDATA = 3'b100,
        OP_RX     = 3'b101,
        OP_STOP   = 3'b110
    } sspc_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_COND = 2'b01,
        ST_BYTE = 2'b10
    } sspc_state_t;

    typedef struct packed {
        logic       parOutputCurrentPin;
        logic       parOutputTermPin;
        logic [1:0] parPreemphasisPins;
        logic       parEqualizerLevelPin;
        logic [1:0] parSourceSelectPins;
        logic       parOutputEnablePin;
    } sspc_par_t;

endpackage : sspc_pkg

/* File: design/sspc_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sspc_sync #(
    parameter int W = 2
) (
    input  wire logic         clock,
    input  wire logic         srst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_bit
            logic meta_ff;
            logic sync_ff;
            always_ff @(posedge clock) begin
                if (srst) begin
                    meta_ff <= 1'b1;
                    sync_ff <= 1'b1;
                end else begin
                    meta_ff <= din[gi];
                    sync_ff <= meta_ff;
                end
            end
            assign dout[gi] = sync_ff;
        end
    endgenerate
endmodule : sspc_sync

/* File: design/sspc_tick.sv */
// quarter-bit tick divider for the serial clock
`timescale 1ns/1ps
`include "sspc_map.svh"
module sspc_tick (
    input  wire logic clock,
    input  wire logic srst,
    input  wire logic clr,
    output logic      tick
);
    localparam logic [15:0] LAST = 16'(`SSPC_SCL_QTR_CYC - 1);
    logic [15:0] cnt_ff;
    logic        tick_ff;

    always_ff @(posedge clock) begin
        if (srst || clr) begin
            cnt_ff  <= 16'h0000;
            tick_ff <= 1'b0;
        end else if (cnt_ff == LAST) begin
            cnt_ff  <= 16'h0000;
            tick_ff <= 1'b1;
        end else begin
            cnt_ff  <= cnt_ff + 16'h0001;
            tick_ff <= 1'b0;
        end
    end
    assign tick = tick_ff;
endmodule : sspc_tick

/* File: tb/sspc_checker.sv */
// port assertions for the switch controller
`timescale 1ns/1ps
module sspc_checker #(
    parameter logic [15:0] RST_LOW_CYC = 16'h4
) (
    input wire logic        clock,
    input wire logic        srst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        sclOut,
    input wire logic        sclOe,
    input wire logic        sdaOut,
    input wire logic        sdaOe,
    input wire logic        devResetN
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    logic [15:0] lowCnt_ff;
    always_ff @(posedge clock) begin
        lowCnt_ff <= (srst || devResetN) ? 16'h0 : lowCnt_ff + 16'h1;
    end
    sequence sdaFall; !sclOe && $rose(sdaOe); endsequence
    sequence sdaRise; !sclOe && $fell(sdaOe); endsequence
    setup_gets_ready_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_in_access_a: assert property (pready |-> penable && $past(psel && !penable))
        else $error("ready outside access");
    rdata_idle_zero_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    lines_open_drain_a: assert property (!sclOut && !sdaOut)
        else $error("line driven high");
    start_then_clock_a: assert property (sdaFall |-> ##[1:200] sclOe)
        else $error("no clock after start");
    stop_frees_bus_a: assert property (sdaRise |=> !sclOe [*8])
        else $error("bus held after stop");
    quiet_in_reset_a: assert property (!devResetN |-> !sclOe && !sdaOe)
        else $error("traffic during device reset");
    pulse_length_a: assert property ($rose(devResetN) |-> lowCnt_ff == RST_LOW_CYC)
        else $error("wrong reset pulse length");
endmodule : sspc_checker

bind sspc_ctrl sspc_checker #(.RST_LOW_CYC(RST_LOW_CYC)) sspc_checker_inst (.clock(clock),
    .srst(srst), .psel(psel), .penable(penable), .pready(pready), .prdata(prdata),
    .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe), .devResetN(devResetN));

/* File: tb/sspc_dev_model.sv */
// behavioural model of the switch's serial control port
`timescale 1ns/1ps
module sspc_dev_model #(
    parameter logic [3:0] PFX = 4'h5 // arbitrary value
) (
    input  wire logic                scl,
    input  wire logic                sda,
    input  wire logic                rstN,
    input  wire logic [2:0]          sel,
    input  wire sspc_pkg::sspc_par_t par,
    output logic                     sdaOe
);
    logic [7:0] mem [256], phys [256];
    bit         win [256];
    // window length grows with the address, so every register has its own
    task automatic upd(input logic [7:0] a);
        if (!win[a]) begin
            win[a] = 1;
            phys[a] = mem[a];
            #(400 + 4 * a);
            phys[a] = mem[a];
            win[a] = 0;
        end
    endtask : upd
    logic [7:0] ptr, sh;
    logic       rd, hit, serial;
    int         bc, ph;
    initial begin
        sdaOe = 0; ph = 3; bc = 0; serial = 0; mem[8'h11] = 8'h0;
    end
    always @(negedge rstN) begin
        serial = 0;
        mem[8'h11] = 8'h0;
    end
    always @(par or rstN) if (!serial || !rstN) begin
        mem[8'h20] = {4'h0, par.parPreemphasisPins, par.parOutputTermPin, par.parOutputCurrentPin};
        fork upd(8'h20); join_none
    end
    always @(negedge sda) if (scl) begin bc = -1; ph = 0; serial = 1; end
    always @(posedge sda) if (scl) ph = 3;
    always @(posedge scl) if (bc < 8) sh = {sh[6:0], sda};
    always @(negedge scl) if (ph != 3) begin
        bc = bc + 1;
        sdaOe = 0;
        if (bc == 8 && ph == 0) hit = sh[7:1] == {PFX, sel};
        if (bc == 8 && ph == 0) rd = sh[0];
        if (bc == 8 && ph == 1) ptr = sh;
        if (bc == 8 && ph == 2) begin
            mem[ptr] = sh;
            fork upd(ptr); join_none
        end
        if (bc == 8 && ph < 3) sdaOe = ph > 0 || hit;
        if (bc == 9) begin
            bc = 0;
            ph = ph == 0 ? (!hit ? 3 : rd ? 4 : 1) : ph == 1 ? 2 : 3;
        end
        if (ph == 4 && bc < 8) sdaOe = !mem[ptr][7 - bc];
    end
endmodule : sspc_dev_model

/* File: tb/tb.sv */
// self-checking bench for the switch controller
`timescale 1ns/1ps
`include "sspc_map.svh"
module tb;
    logic        clock = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, alien = 0, err, devOe;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        pready, pslverr, sclOut, sclOe, sdaOut, sdaOe, devResetN, s2, s1, s0;
    sspc_pkg::sspc_par_t parPins;
    int          failures = 0, n_compared = 0;
    wire         sclW = !sclOe;
    wire         sdaW = !(sdaOe || devOe);
    always #12.5 clock = ~clock;
    sspc_ctrl #(.RST_LOW_CYC(16'h4)) sspc_ctrl_inst (.clock(clock), .srst(srst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sclIn(sclW), .sclOut(sclOut), .sclOe(sclOe),
        .sdaIn(sdaW), .sdaOut(sdaOut), .sdaOe(sdaOe), .devResetN(devResetN),
        .slaveAddrSelBit2(s2), .slaveAddrSelBit1(s1), .slaveAddrSelBit0(s0), .parPins(parPins));
    sspc_dev_model sspc_dev_model_inst (.scl(sclW), .sda(sdaW), .rstN(devResetN),
        .sel({s2, s1, s0 ^ alien}), .par(parPins), .sdaOe(devOe));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin failures++; $display("BAD %s exp %h got %h", nm, e, g); end
    endtask : chk
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clock);
        paddr <= a; pwrite <= w; pwdata <= d; psel <= 1'b1;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        q = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic idle();
        repeat (2) @(posedge clock);
        do apb(`SSPC_OFF_STAT, 1'b0, 32'h0); while ((q & 32'h9) != 32'h0);
    endtask : idle
    task automatic xfer(input sspc_pkg::sspc_kind_t k, input logic [7:0] r, input logic [7:0] d);
        apb(`SSPC_OFF_ADDR, 1'b1, {16'h0, r, 8'h05});
        apb(`SSPC_OFF_WDATA, 1'b1, {24'h0, d});
        apb(`SSPC_OFF_CMD, 1'b1, {30'h0, k});
        idle();
        apb(`SSPC_OFF_RDATA, 1'b0, 32'h0);
    endtask : xfer
    task automatic test_done();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done
    initial begin
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        apb(`SSPC_OFF_PAR, 1'b0, 32'h0); chk("par", 32'h01, q);
        apb(`SSPC_OFF_STAT, 1'b0, 32'h0); chk("stat", 32'h0, q);
        apb(8'h1c, 1'b0, 32'h0); chk("slverr", 32'h1, {31'h0, err});
        xfer(sspc_pkg::K_WRITE, 8'h20, 8'ha6);
        apb(`SSPC_OFF_STAT, 1'b0, 32'h0);
        chk("serial", 32'h4, q & 32'h6);
        chk("applied", 32'ha6, {24'h0, sspc_dev_model_inst.phys[8'h20]});
        xfer(sspc_pkg::K_READ, 8'h20, 8'h0); chk("rd", 32'ha6, q);
        xfer(sspc_pkg::K_WRITE, 8'h11, 8'h3c);
        xfer(sspc_pkg::K_CUR, 8'h0, 8'h0); chk("cur", 32'h3c, q);
        alien <= 1'b1;
        xfer(sspc_pkg::K_WRITE, 8'h12, 8'h1); idle(); chk("nack", 32'h6, q);
        alien <= 1'b0;
        apb(`SSPC_OFF_PAR, 1'b1, 32'he7); idle(); chk("pins", 32'he7, {24'h0, parPins});
        chk("cleared", 32'h0, q & 32'h4);
        xfer(sspc_pkg::K_READ, 8'h20, 8'h0); chk("pinreg", 32'h0b, q);
        xfer(sspc_pkg::K_READ, 8'h11, 8'h0); chk("termreg", 32'h0, q);
        test_done();
    end
    initial begin
        repeat (95000) @(posedge clock);
        failures++;
        test_done();
    end
endmodule : tb
